//--- verilog/wdt_top.sv
// watchdog timer with feed lock behind an ahb-lite slave port
//
// Functional notes
// RULE_01 - 32-bit down-counter decrements once per divide-by-4 prescaler tick.
// RULE_02 - Reload writes below 0xFF store 0xFF instead.
// RULE_03 - Reload register is 32 bits, resets to 0xFF.
// RULE_04 - Feed write 0xAA then 0x55 reloads counter from reload register.
// RULE_05 - Enable alone does not start; first valid feed with enable starts it.
// RULE_06 - Feed errors ignored until first valid feed has started the counter.
// RULE_07 - After 0xAA, any access other than feed write 0x55 triggers action.
// RULE_08 - Action from a bad feed access appears in second cycle after it.
// RULE_09 - Enable clear: idle; enable only: interrupt; both: interrupt and reset.
// RULE_10 - Enable bits are set-only by software; cleared only by a system or watchdog reset.
// RULE_11 - Timeout flag bit 2 set on timeout, software clears, survives watchdog reset.
// RULE_12 - Read-only interrupt flag bit 3 set on timeout, cleared by any reset.
// RULE_13 - Mode: enable bit 0, reset-enable bit 1, bits 7:4 reserved, reset zero.
// RULE_14 - Underflow with reset enabled requests a full system reset.
// RULE_15 - Value register reads the live counter, resetting to 0xFF.
// RULE_16 - Feed register is write-only, 8-bit, only 0xAA then 0x55 feeds.
// RULE_17 - Software programs reload, then mode, then feeds, and refeeds in time.
// RULE_18 - Software writes no ones to reserved mode bits; reads are undefined.
// RULE_19 - Interrupt output follows interrupt flag; reset request is a one-cycle pulse.
// RULE_20 - Underflow is decrement from zero; interrupt-only mode reloads and continues.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "wdt_defs.svh"

module wdt_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic wdt_irq,
  output logic wdt_reset_req
);
  import wdt_pkg::*;

  // ==========================================================
  // helpers
  function automatic wdt_reg_type decode_reg(input logic [31:0] addr);
    wdt_reg_type sel;
    sel = WDT_REG_NONE;
    if (addr == `WDT_OFS_MODE)
    begin
      sel = WDT_REG_MODE;
    end
    else if (addr == `WDT_OFS_RELOAD)
    begin
      sel = WDT_REG_RELOAD;
    end
    else if (addr == `WDT_OFS_FEED)
    begin
      sel = WDT_REG_FEED;
    end
    else if (addr == `WDT_OFS_VALUE)
    begin
      sel = WDT_REG_VALUE;
    end
    return sel;
  endfunction

  function automatic logic [31:0] clamp_reload(input logic [31:0] val);
    logic [31:0] res;
    res = val;
    if (val < `WDT_RELOAD_MIN)
    begin
      res = `WDT_RELOAD_MIN;
    end
    return res;
  endfunction

  // ==========================================================
  // state
  logic dp_valid;
  logic dp_write;
  wdt_reg_type dp_reg;
  wdt_feed_state_type feed_state;
  logic enable_set_only_bit;
  logic reset_action_enable_bit;
  logic timeout_flag;
  logic interrupt_flag;
  logic started;
  logic [1:0] prescale;
  logic [31:0] timeout_reload_constant;
  logic [31:0] counter_current_value;
  logic err_pending;

  logic access_go;
  logic wr_mode;
  logic wr_reload;
  logic wr_feed;
  logic feed_first;
  logic feed_valid;
  logic seq_error;
  logic running;
  logic tick;
  logic underflow;
  logic timeout;
  logic wd_reset;
  logic [31:0] next_rdata;

  // ==========================================================
  // bus decode
  assign access_go = hsel && htrans[1] && hready;
  assign wr_mode = dp_valid && dp_write && (dp_reg == WDT_REG_MODE);
  assign wr_reload = dp_valid && dp_write && (dp_reg == WDT_REG_RELOAD);
  assign wr_feed = dp_valid && dp_write && (dp_reg == WDT_REG_FEED);
  assign feed_first = wr_feed && (hwdata[7:0] == `WDT_FEED_FIRST) && (feed_state == WDT_FEED_IDLE); // RULE_16
  assign feed_valid = wr_feed && (hwdata[7:0] == `WDT_FEED_SECOND) && (feed_state == WDT_FEED_ARMED); // RULE_04
  // any watchdog access, read or write, breaks an armed sequence unless it is the closing feed
  assign seq_error = dp_valid && (dp_reg != WDT_REG_NONE) && (feed_state == WDT_FEED_ARMED) && !feed_valid; // RULE_07

  // ==========================================================
  // counter control
  assign running = started && enable_set_only_bit; // RULE_09
  assign tick = running && (prescale == `WDT_PRESCALE_LAST); // RULE_01
  assign underflow = tick && (counter_current_value == 32'h0000_0000); // RULE_20
  assign timeout = underflow || err_pending;
  // the pulse itself acts as the block's own reset one cycle after the timeout
  assign wd_reset = wdt_reset_req;

  // ==========================================================
  // ahb-lite data phase tracking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_reg <= WDT_REG_NONE;
    end
    else if (hready)
    begin
      dp_valid <= access_go;
      dp_write <= hwrite;
      dp_reg <= decode_reg(haddr);
    end
  end

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // read data, captured in the address phase
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (decode_reg(haddr))
      WDT_REG_MODE:
      begin
        next_rdata[`WDT_MODE_EN_BIT] = enable_set_only_bit; // RULE_13
        next_rdata[`WDT_MODE_RST_BIT] = reset_action_enable_bit;
        next_rdata[`WDT_MODE_TOF_BIT] = timeout_flag;
        next_rdata[`WDT_MODE_INT_BIT] = interrupt_flag;
      end
      WDT_REG_RELOAD:
      begin
        next_rdata = timeout_reload_constant;
      end
      WDT_REG_VALUE:
      begin
        next_rdata = counter_current_value; // RULE_15
      end
      WDT_REG_FEED, WDT_REG_NONE:
      begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (access_go && !hwrite)
    begin
      hrdata <= next_rdata;
    end
  end

  // ==========================================================
  // feed sequence
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      feed_state <= WDT_FEED_IDLE;
    end
    else if (wd_reset)
    begin
      feed_state <= WDT_FEED_IDLE;
    end
    else
    begin
      unique case (feed_state)
        WDT_FEED_IDLE:
        begin
          if (feed_first)
          begin
            feed_state <= WDT_FEED_ARMED;
          end
        end
        WDT_FEED_ARMED:
        begin
          if (dp_valid && (dp_reg != WDT_REG_NONE))
          begin
            feed_state <= WDT_FEED_IDLE;
          end
        end
        default:
        begin
          feed_state <= WDT_FEED_IDLE;
        end
      endcase
    end
  end

  // one stage of delay puts the action in the second cycle after the bad access
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      err_pending <= 1'b0;
    end
    else
    begin
      err_pending <= seq_error && running && !wd_reset; // RULE_06 RULE_08
    end
  end

  // ==========================================================
  // mode bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable_set_only_bit <= 1'b0;
      reset_action_enable_bit <= 1'b0;
    end
    else if (wd_reset)
    begin
      enable_set_only_bit <= 1'b0; // RULE_10
      reset_action_enable_bit <= 1'b0;
    end
    else if (wr_mode)
    begin
      enable_set_only_bit <= enable_set_only_bit | hwdata[`WDT_MODE_EN_BIT]; // RULE_10
      reset_action_enable_bit <= reset_action_enable_bit | hwdata[`WDT_MODE_RST_BIT];
    end
  end

  // survives the watchdog reset; a new timeout wins over a software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timeout_flag <= 1'b0;
    end
    else if (timeout)
    begin
      timeout_flag <= 1'b1; // RULE_11
    end
    else if (wr_mode && !hwdata[`WDT_MODE_TOF_BIT])
    begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      interrupt_flag <= 1'b0;
    end
    else if (wd_reset)
    begin
      interrupt_flag <= 1'b0; // RULE_12
    end
    else if (timeout)
    begin
      interrupt_flag <= 1'b1; // RULE_12
    end
  end

  // ==========================================================
  // reload register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timeout_reload_constant <= `WDT_RELOAD_RESET; // RULE_03
    end
    else if (wr_reload)
    begin
      timeout_reload_constant <= clamp_reload(hwdata); // RULE_02
    end
  end

  // ==========================================================
  // start latch, prescaler and counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      started <= 1'b0;
    end
    else if (wd_reset || (timeout && reset_action_enable_bit))
    begin
      started <= 1'b0;
    end
    else if (feed_valid && enable_set_only_bit)
    begin
      started <= 1'b1; // RULE_05
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prescale <= 2'h0;
    end
    else if (!running || feed_valid || wd_reset)
    begin
      prescale <= 2'h0;
    end
    else
    begin
      prescale <= prescale + 2'h1; // RULE_01
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      counter_current_value <= `WDT_VALUE_RESET; // RULE_15
    end
    else if (wd_reset)
    begin
      counter_current_value <= `WDT_VALUE_RESET;
    end
    else if (feed_valid || underflow)
    begin
      counter_current_value <= timeout_reload_constant; // RULE_04 RULE_20
    end
    else if (tick)
    begin
      counter_current_value <= counter_current_value - 32'h0000_0001; // RULE_01
    end
  end

  // ==========================================================
  // action outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wdt_reset_req <= 1'b0;
      wdt_irq <= 1'b0;
    end
    else
    begin
      wdt_reset_req <= timeout && reset_action_enable_bit && !wd_reset; // RULE_14 RULE_19
      // one cycle behind the flag so the pin tracks it as a level
      wdt_irq <= interrupt_flag; // RULE_09 RULE_19
    end
  end

endmodule

//--- common/wdt_defs.svh
// watchdog register offsets, field positions, reset values and timing counts
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ==========================================================
// register byte addresses
`define WDT_OFS_MODE 32'he000_0000
`define WDT_OFS_RELOAD 32'he000_0004
`define WDT_OFS_FEED 32'he000_0008
`define WDT_OFS_VALUE 32'he000_000c

// ==========================================================
// mode register fields
`define WDT_MODE_EN_BIT 0
`define WDT_MODE_RST_BIT 1
`define WDT_MODE_TOF_BIT 2
`define WDT_MODE_INT_BIT 3

// ==========================================================
// reset values and feed codes
`define WDT_RELOAD_RESET 32'h0000_00ff
`define WDT_RELOAD_MIN 32'h0000_00ff
`define WDT_VALUE_RESET 32'h0000_00ff
`define WDT_FEED_FIRST 8'haa
`define WDT_FEED_SECOND 8'h55

// ==========================================================
// timing
`define WDT_PRESCALE_DIV 4
`define WDT_PRESCALE_LAST 2'h3

`endif

//--- common/wdt_pkg.sv
// watchdog types used by the design module
package wdt_pkg;

  // ==========================================================
  // feed sequence tracker
  typedef enum logic [1:0]
  {
    WDT_FEED_IDLE = 2'b01,
    WDT_FEED_ARMED = 2'b10
  } wdt_feed_state_type;

  // ==========================================================
  // decoded register selection
  typedef enum logic [2:0]
  {
    WDT_REG_NONE = 3'h0,
    WDT_REG_MODE = 3'h1,
    WDT_REG_RELOAD = 3'h2,
    WDT_REG_FEED = 3'h3,
    WDT_REG_VALUE = 3'h4
  } wdt_reg_type;

endpackage

//--- bench/wdt_top_properties.sv
// checker for the watchdog bus port and action outputs
`timescale 1ns/1ns
`include "wdt_defs.svh"

module wdt_top_properties
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic wdt_irq,
  input wire logic wdt_reset_req
);
  // ==========================================================
  // properties
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd_take = hsel && htrans[1] && hready && !hwrite;

  a_always_ready: assert property (hreadyout)
    else $error("slave not ready");
  a_resp_okay: assert property (!hresp)
    else $error("slave answered with error");
  a_zero_read: assert property (
    rd_take && !(haddr inside {`WDT_OFS_MODE, `WDT_OFS_RELOAD, `WDT_OFS_VALUE}) |=> hrdata == 32'h0)
    else $error("feed or unmapped read not zero");
  a_reload_floor: assert property (
    rd_take && haddr == `WDT_OFS_RELOAD |=> hrdata >= `WDT_RELOAD_MIN)
    else $error("reload below floor");
  a_pulse_single: assert property (wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request longer than one cycle");
  // enables are cleared by the pulse; re-arming takes a mode write and two feeds, so the gap is at least six cycles
  a_pulse_quiet: assert property (wdt_reset_req |-> ##2 !wdt_reset_req [*4])
    else $error("reset request repeated");
  a_pulse_clears_irq: assert property (wdt_reset_req |=> wdt_irq ##1 !wdt_irq)
    else $error("interrupt not cleared by watchdog reset");
  a_irq_fall: assert property ($fell(wdt_irq) |-> $past(wdt_reset_req, 2))
    else $error("interrupt dropped without reset");

  cover property (wdt_reset_req);
  cover property (wdt_irq [*3]);
  cover property (rd_take && haddr == `WDT_OFS_RELOAD);
endmodule

bind wdt_top wdt_top_properties wdt_top_properties_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req));

//--- bench/test_wdt_top.sv
// self-checking bench for the watchdog over its ahb-lite port
`timescale 1ns/1ns
`include "wdt_defs.svh"

module test_wdt_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv, v1;
  logic hready, hreadyout, hresp, wdt_irq, wdt_reset_req;
  int err_total = 0, checked = 0, i;
  assign hready = hreadyout;

  wdt_top wdt_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req));

  initial
  begin
    forever #2 hclk = ~hclk;
  end

  // ==========================================================
  // bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rv & m, e);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_total++;
    complete_run;
  end

  // ==========================================================
  // scenarios
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`WDT_OFS_MODE, 32'hf, 32'h0);
    rdc(`WDT_OFS_RELOAD, 32'hffffffff, 32'hff);
    rdc(`WDT_OFS_VALUE, 32'hffffffff, 32'hff);
    rdc(`WDT_OFS_FEED, 32'hffffffff, 32'h0);
    rdc(32'he0000010, 32'hffffffff, 32'h0);
    xfer(1'b1, `WDT_OFS_RELOAD, 32'h10);
    rdc(`WDT_OFS_RELOAD, 32'hffffffff, 32'hff);
    xfer(1'b1, `WDT_OFS_MODE, 32'h1);
    xfer(1'b1, `WDT_OFS_MODE, 32'h0);
    rdc(`WDT_OFS_MODE, 32'hf, 32'h1);
    // broken feed before the first start must stay silent
    xfer(1'b1, `WDT_OFS_FEED, 32'haa);
    rdc(`WDT_OFS_VALUE, 32'hffffffff, 32'hff);
    repeat (20) @(posedge hclk);
    #1 chk({30'h0, wdt_irq, wdt_reset_req}, 32'h0);
    rdc(`WDT_OFS_VALUE, 32'hffffffff, 32'hff);
    xfer(1'b1, `WDT_OFS_RELOAD, 32'h300);
    xfer(1'b1, `WDT_OFS_FEED, 32'haa);
    xfer(1'b1, `WDT_OFS_FEED, 32'h55);
    xfer(1'b0, `WDT_OFS_VALUE, 32'h0);
    v1 = rv;
    chk({31'h0, v1 >= 32'h2fe && v1 <= 32'h300}, 32'h1);
    // 41 cycles between the two loads of read data, holding exactly 10 ticks
    repeat (38) @(posedge hclk);
    rdc(`WDT_OFS_VALUE, 32'hffffffff, v1 - 32'ha);
    i = 0;
    while (wdt_irq !== 1'b1 && i < 4000)
    begin
      @(posedge hclk);
      i++;
    end
    rdc(`WDT_OFS_MODE, 32'hf, 32'hd);
    // interrupt-only timeout: the pin stays up as a level
    chk({31'h0, wdt_irq}, 32'h1);
    xfer(1'b1, `WDT_OFS_MODE, 32'h3);
    rdc(`WDT_OFS_MODE, 32'hf, 32'hb);
    chk({31'h0, wdt_irq}, 32'h1);
    xfer(1'b1, `WDT_OFS_FEED, 32'haa);
    xfer(1'b1, `WDT_OFS_FEED, 32'h55);
    xfer(1'b1, `WDT_OFS_FEED, 32'haa);
    xfer(1'b0, `WDT_OFS_MODE, 32'h0);
    @(posedge hclk);
    #1 chk({31'h0, wdt_reset_req}, 32'h1);
    @(posedge hclk);
    #1 chk({31'h0, wdt_reset_req}, 32'h0);
    rdc(`WDT_OFS_MODE, 32'hf, 32'h4);
    rdc(`WDT_OFS_RELOAD, 32'hffffffff, 32'h300);
    rdc(`WDT_OFS_VALUE, 32'hffffffff, 32'hff);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`WDT_OFS_MODE, 32'hf, 32'h0);
    complete_run;
  end
endmodule
